/* rtl/asr_top.sv */
/*
  Serial result output of the converter plus a result FIFO.
  asr_fifo: flip-flop FIFO with valid/ready on both sides.
  asr_top : link logic on the serial clock, chip select high clears all of it but the crossing source;
  finished results cross into the system clock domain and are queued.
  Assumes the host drives serial_in_line and lsb_order_select in step
  with the serial clock, and that the comparator decision arrives on
  cmp_in in time for each falling serial clock edge.
*/
// Summary of operation
// - Finished result copied into output shift register
// - Select high holds least significant bit steady
// - Select low shifts result out LSB first
// - Without select, LSB-first replay follows automatically
// - After final bit, output low until deselect
// - Optional variant sends MSB first only
// - Chip select high clears all link registers except the crossing source
// - Serial input ignored once conversion starts
// - Negative input sampled half clock after positive
// - Result is unsigned eight bit code
// - Leading zeros skipped, first one starts address
// - Output leaves high impedance with leading zero
// - Result bits MSB first on falling edges
// - Eight periods convert, flag falls one period later
`timescale 1ns/1ps

module asr_fifo #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
  localparam logic [AW:0]   CNT_FULL = (AW + 1)'(DEPTH);

  if (DEPTH < 2 || WIDTH < 1) begin : g_bad_fifo
    $error("asr_fifo needs DEPTH of at least 2 and WIDTH of at least 1");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             push;
  logic             pop;

  function automatic logic [AW-1:0] ptr_next(input logic [AW-1:0] p);
    ptr_next = (p == PTR_LAST) ? '0 : p + 1'b1;
  endfunction

  assign in_ready  = (cnt_q != CNT_FULL);
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_q[rd_ptr_q];
  assign cnt_d     = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q    <= '0;
    end else begin
      cnt_q <= cnt_d;
      if (push) begin
        wr_ptr_q <= ptr_next(wr_ptr_q);
      end
      if (pop) begin
        rd_ptr_q <= ptr_next(rd_ptr_q);
      end
    end
  end

  // Storage needs no reset; it is read only behind the count
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end
endmodule // asr_fifo

module asr_top
  import asr_pkg::*;
#(
  parameter logic [1:0]  ORDER_MODE   = ORDER_SELECT,
  parameter int unsigned ADDR_WIDTH   = ADDR_BITS,
  parameter int unsigned BUFFER_DEPTH = FIFO_DEPTH
) (
  input  wire logic                         clk,
  input  wire logic                         resetn,
  input  wire logic                         serial_clk,
  input  wire logic                         cs_n,
  input  wire logic                         serial_in_line,
  input  wire logic                         lsb_order_select,
  input  wire logic                         cmp_in,
  output logic                              serial_out_line,
  output logic                              serial_out_oe_n,
  output logic                              conversion_active_flag,
  output logic                              sample_pos,
  output logic                              sample_neg,
  output logic      [ADDR_MAX-1:0]          mux_addr,
  output logic                              res_valid,
  input  wire logic                         res_ready,
  output logic      [ADDR_MAX+RESULT_BITS-1:0] res_data,
  output logic                              res_overrun
);
  localparam int unsigned WORD_W = ADDR_MAX + RESULT_BITS;
  localparam logic [CNT_W-1:0] ADDR_LAST = CNT_W'(ADDR_WIDTH - 1);
  localparam logic [CNT_W-1:0] RES_DONE  = CNT_W'(RESULT_BITS);
  localparam logic [CNT_W-1:0] RES_LAST  = CNT_W'(RESULT_BITS - 1);

  if (ADDR_WIDTH < ADDR_MIN || ADDR_WIDTH > ADDR_MAX ||
      ORDER_MODE > ORDER_SELECT) begin : g_bad_cfg
    $error("asr_top: address width or output order out of range");
  end

  typedef enum logic [1:0] {AD_IDLE, AD_SHIFT, AD_DONE} asr_ad_type;
  typedef enum logic [1:0] {CV_WAIT, CV_BITS, CV_REPLAY, CV_LOW} asr_cv_type;

  // Link side, rising edges: start bit and address
  asr_ad_type                ad_state_q;
  logic [CNT_W-1:0]          ad_cnt_q;
  logic [ADDR_MAX-1:0]       addr_q;
  logic                      addr_done_q;
  logic                      sample_pos_q;
  // Link side, falling edges: conversion and output
  asr_cv_type                cv_state_q;
  logic [CNT_W-1:0]          cv_cnt_q;
  logic [RESULT_BITS-1:0]    sar_q;
  logic [RESULT_BITS-1:0]    shift_q;
  logic                      dout_q;
  logic                      oe_n_q;
  logic                      busy_q;
  logic                      sample_neg_q;
  logic                      xfer_tgl_q;
  logic [WORD_W-1:0]         xfer_word_q;
  // System side
  logic [2:0]                tgl_sync_q;
  logic                      tgl_seen_q;
  logic                      pend_q;
  logic [WORD_W-1:0]         pend_word_q;
  logic                      overrun_q;
  logic                      fifo_in_ready;

  wire last_addr_bit = (ad_state_q == AD_SHIFT) && (ad_cnt_q == ADDR_LAST);
  wire conv_done     = (cv_state_q == CV_BITS) && (cv_cnt_q == RES_DONE);
  wire replay_step   = (ORDER_MODE == ORDER_AUTO) || !lsb_order_select;
  wire last_replay   = (cv_cnt_q == RES_LAST);
  wire tgl_agree     = (tgl_sync_q[1] == tgl_sync_q[2]);
  wire new_result    = tgl_agree && (tgl_sync_q[2] != tgl_seen_q);
  wire pend_taken    = pend_q && fifo_in_ready;

  // Start bit and address on rising edges; cs high clears all
  always_ff @(posedge serial_clk or posedge cs_n) begin
    if (cs_n) begin
      ad_state_q   <= AD_IDLE;
      ad_cnt_q     <= CNT_RST;
      addr_q       <= ADDR_RST;
      addr_done_q  <= 1'b0;
      sample_pos_q <= 1'b0;
    end else begin
      sample_pos_q <= 1'b0;
      case (ad_state_q)
        AD_IDLE: begin
          if (serial_in_line) begin
            ad_state_q <= AD_SHIFT;
            ad_cnt_q   <= CNT_RST;
          end
        end
        AD_SHIFT: begin
          addr_q   <= {addr_q[ADDR_MAX-2:0], serial_in_line};
          ad_cnt_q <= ad_cnt_q + CNT_ONE;
          if (last_addr_bit) begin
            ad_state_q   <= AD_DONE;
            addr_done_q  <= 1'b1;
            sample_pos_q <= 1'b1;
          end
        end
        // Input no longer looked at once addressing ends
        AD_DONE: ad_state_q <= AD_DONE;
        default: ad_state_q <= AD_IDLE;
      endcase
    end
  end

  // Conversion and output on falling edges
  always_ff @(negedge serial_clk or posedge cs_n) begin
    if (cs_n) begin
      cv_state_q   <= CV_WAIT;
      cv_cnt_q     <= CNT_RST;
      sar_q        <= RESULT_RST;
      shift_q      <= RESULT_RST;
      dout_q       <= 1'b0;
      oe_n_q       <= 1'b1;
      busy_q       <= 1'b0;
      sample_neg_q <= 1'b0;
    end else begin
      sample_neg_q <= 1'b0;
      case (cv_state_q)
        CV_WAIT: begin
          if (addr_done_q) begin
            // Half a period after the positive input was taken
            sample_neg_q <= 1'b1;
            busy_q       <= 1'b1;
            oe_n_q       <= 1'b0;
            dout_q       <= 1'b0;
            cv_cnt_q     <= CNT_RST;
            cv_state_q   <= CV_BITS;
          end
        end
        CV_BITS: begin
          if (conv_done) begin
            busy_q   <= 1'b0;
            shift_q  <= sar_q;
            cv_cnt_q <= CNT_RST;
            if (ORDER_MODE == ORDER_MSB_ONLY) begin
              dout_q     <= 1'b0;
              cv_state_q <= CV_LOW;
            end else begin
              // LSB is already on the line and is held
              dout_q     <= sar_q[0];
              cv_state_q <= CV_REPLAY;
            end
          end else begin
            dout_q   <= cmp_in;
            sar_q    <= {sar_q[RESULT_BITS-2:0], cmp_in};
            cv_cnt_q <= cv_cnt_q + CNT_ONE;
          end
        end
        CV_REPLAY: begin
          if (replay_step) begin
            if (last_replay) begin
              dout_q     <= 1'b0;
              cv_state_q <= CV_LOW;
            end else begin
              dout_q   <= shift_q[1];
              shift_q  <= {1'b0, shift_q[RESULT_BITS-1:1]};
              cv_cnt_q <= cv_cnt_q + CNT_ONE;
            end
          end
        end
        CV_LOW:  dout_q <= 1'b0;
        default: cv_state_q <= CV_WAIT;
      endcase
    end
  end

  // Crossing source; kept apart from the cs clear so a deselect
  // right after completion cannot corrupt a word in flight
  always_ff @(negedge serial_clk or negedge resetn) begin
    if (!resetn) begin
      xfer_tgl_q  <= 1'b0;
      xfer_word_q <= '0;
    end else if (conv_done) begin
      xfer_tgl_q  <= ~xfer_tgl_q;
      xfer_word_q <= {addr_q, sar_q};
    end
  end

  // Toggle through three stages; counted when stages two and three agree
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tgl_sync_q <= 3'h0;
      tgl_seen_q <= 1'b0;
    end else begin
      tgl_sync_q <= {tgl_sync_q[1:0], xfer_tgl_q};
      if (new_result) begin
        tgl_seen_q <= tgl_sync_q[2];
      end
    end
  end

  // One word waits for the FIFO; a second arrival meanwhile is lost
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pend_q      <= 1'b0;
      pend_word_q <= '0;
      overrun_q   <= 1'b0;
    end else begin
      overrun_q <= new_result && pend_q && !pend_taken;
      if (new_result && (!pend_q || pend_taken)) begin
        pend_q      <= 1'b1;
        pend_word_q <= xfer_word_q;
      end else if (pend_taken) begin
        pend_q <= 1'b0;
      end
    end
  end

  asr_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (BUFFER_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .resetn    (resetn),
    .in_valid  (pend_q),
    .in_ready  (fifo_in_ready),
    .in_data   (pend_word_q),
    .out_valid (res_valid),
    .out_ready (res_ready),
    .out_data  (res_data)
  );

  assign serial_out_line        = dout_q;
  assign serial_out_oe_n        = oe_n_q;
  assign conversion_active_flag = busy_q;
  assign sample_pos             = sample_pos_q;
  assign sample_neg             = sample_neg_q;
  assign mux_addr               = addr_q;
  assign res_overrun            = overrun_q;
endmodule // asr_top

/* rtl/asr_pkg.sv */
/*
  Constants shared by the serial result-output block of an 8-bit
  successive-approximation converter: result width, address word width,
  output-order variants and crossing depth.
  Assumes the serial clock is the only clock of the converter link and
  that a second, free-running system clock collects finished results.
*/
package asr_pkg;

  // Result code width, unsigned, 256 codes
  localparam int unsigned RESULT_BITS  = 8;
  // Channel assignment word after the start bit
  localparam int unsigned ADDR_BITS    = 4;
  localparam int unsigned ADDR_MIN     = 2;
  localparam int unsigned ADDR_MAX     = 4;
  // Counter widths used at the link
  localparam int unsigned CNT_W        = 4;
  // Output order variants
  localparam logic [1:0]  ORDER_MSB_ONLY = 2'h0;
  localparam logic [1:0]  ORDER_AUTO     = 2'h1;
  localparam logic [1:0]  ORDER_SELECT   = 2'h2;
  // Result buffer between link and system side
  localparam int unsigned FIFO_DEPTH   = 8;
  // Reset values and counter step
  localparam logic [RESULT_BITS-1:0] RESULT_RST = 8'h00;
  localparam logic [ADDR_MAX-1:0]    ADDR_RST   = 4'h0;
  localparam logic [CNT_W-1:0]       CNT_RST    = 4'h0;
  localparam logic [CNT_W-1:0]       CNT_ONE    = 4'h1;

endpackage

/* verif/asr_top_checker.sv */
/* Checker of the asr_top ports on both clocks.
   Assumes it is bound to asr_top. */
`timescale 1ns/1ps
module asr_top_checker #(
  parameter logic [1:0] ORDER_MODE = 2'h2
) (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        serial_clk,
  input wire logic        cs_n,
  input wire logic        serial_in_line,
  input wire logic        lsb_order_select,
  input wire logic        cmp_in,
  input wire logic        serial_out_line,
  input wire logic        serial_out_oe_n,
  input wire logic        conversion_active_flag,
  input wire logic        sample_pos,
  input wire logic        sample_neg,
  input wire logic [3:0]  mux_addr,
  input wire logic        res_valid,
  input wire logic        res_ready,
  input wire logic [11:0] res_data,
  input wire logic        res_overrun
);
  logic [3:0] step_q;
  // Replay steps taken; saturates so a long tail cannot wrap
  always_ff @(negedge serial_clk or posedge cs_n)
    if (cs_n)
      step_q <= 4'h0;
    else if (!conversion_active_flag && !serial_out_oe_n
             && !lsb_order_select && step_q != 4'hf)
      step_q <= step_q + 4'h1;

  chk_desel_release: assert property (
    @(posedge clk) disable iff (!resetn) cs_n && $past(cs_n)
    |-> serial_out_oe_n && !conversion_active_flag) else $error("release");
  chk_desel_clear: assert property (
    @(posedge clk) disable iff (!resetn) cs_n && $past(cs_n)
    |-> !serial_out_line && !sample_pos && mux_addr == 4'h0) else $error("clr");
  chk_lead_zero: assert property (
    @(negedge serial_clk) disable iff (cs_n) $fell(serial_out_oe_n)
    |-> !serial_out_line && conversion_active_flag) else $error("lead");
  chk_busy_length: assert property (
    @(negedge serial_clk) disable iff (cs_n) $rose(conversion_active_flag)
    |-> conversion_active_flag [*8] ##1 conversion_active_flag
    ##1 !conversion_active_flag) else $error("busy length");
  chk_neg_follows: assert property (
    @(posedge serial_clk) disable iff (cs_n) $rose(sample_pos)
    |-> sample_neg ##1 !sample_neg) else $error("neg sample");
  chk_input_ignored: assert property (
    @(posedge serial_clk) disable iff (cs_n)
    conversion_active_flag && $past(conversion_active_flag)
    |-> $stable(mux_addr)) else $error("input ignored");
  chk_select_holds: assert property (
    @(negedge serial_clk) disable iff (cs_n) ORDER_MODE == 2'h2
    && !conversion_active_flag && !serial_out_oe_n && lsb_order_select
    |=> $stable(serial_out_line)) else $error("select hold");
  chk_tail_low: assert property (
    @(negedge serial_clk) disable iff (cs_n) step_q >= 4'h8
    |-> !serial_out_line) else $error("tail low");
  cov_overrun: cover property (@(posedge clk) res_overrun);
  cov_pop: cover property (@(posedge clk) res_valid && res_ready);
  cov_tail: cover property (@(negedge serial_clk) step_q == 4'h9);
endmodule // asr_top_checker

bind asr_top asr_top_checker #(.ORDER_MODE(ORDER_MODE)) u_chk (.clk(clk),
  .resetn(resetn),
  .serial_clk(serial_clk), .cs_n(cs_n), .serial_in_line(serial_in_line),
  .lsb_order_select(lsb_order_select), .cmp_in(cmp_in),
  .serial_out_line(serial_out_line), .serial_out_oe_n(serial_out_oe_n),
  .conversion_active_flag(conversion_active_flag),
  .sample_pos(sample_pos), .sample_neg(sample_neg), .mux_addr(mux_addr),
  .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data),
  .res_overrun(res_overrun));

/* verif/asr_host_model.sv */
/* Host at the far end of the link: framed 15 ns clock, start bit,
   address, comparator bits; records the output at each rising edge. */
`timescale 1ns/1ps
module asr_host_model (
  output logic      serial_clk,
  output logic      cs_n,
  output logic      serial_in_line,
  output logic      lsb_order_select,
  output logic      cmp_in,
  input  wire logic serial_out_line,
  input  wire logic serial_out_oe_n
);
  logic host_di;
  logic seen[$];
  // One shared wire, released while the device drives it
  assign serial_in_line = serial_out_oe_n ? host_di : serial_out_line;
  initial begin
    {serial_clk, host_di, lsb_order_select, cmp_in} = 4'h0;
    cs_n = 1'b1;
  end
  task automatic cyc(input logic di, input logic cmp, input logic sel);
    {host_di, cmp_in, lsb_order_select} = {di, cmp, sel};
    #4 serial_clk = 1'b1;
    seen.push_back(serial_in_line);
    #7.5 serial_clk = 1'b0;
    #3.5;
  endtask
  task automatic frame(input logic [3:0] a, input logic [7:0] r, input int n);
    cs_n = 1'b0;
    #5;
    cyc(1'b0, 1'b0, 1'b1);
    cyc(1'b0, 1'b0, 1'b1);
    cyc(1'b1, 1'b0, 1'b1);
    for (int i = 3; i >= 0; i--)
      cyc(a[i], 1'b0, 1'b1);
    seen.delete();
    for (int c = 1; c <= n; c++)
      cyc(1'b1, c <= 8 ? r[8-c] : 1'b0, c < 11);
    // Clock stands still, then deselect before any new frame
    #5 cs_n = 1'b1;
    #20;
  endtask
endmodule // asr_host_model

/* verif/test_adc_serial_result_output.sv */
/* Self-checking bench: asr_top with the host model and a queue model.
   Assumes 4 address bits; main instance uses select pin order, two
   more instances run auto replay and MSB-only order on the same link. */
`timescale 1ns/1ps
`define CHECK(w, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH %s exp %0h got %0h", w, e, g); end end
module test_adc_serial_result_output;
  logic        clk, resetn, res_ready;
  wire         sclk, cs_n, sdi, sel, cmp, sdo, oe_n, busy, ovr, rvalid;
  wire  [3:0]  addr;
  wire  [11:0] rdata;
  int          bad_count, n_tests, n_ovr;
  integer      seed = 32'h54c20df0;
  logic [11:0] exp_q[$];
  wire         sdo_auto, sdo_msb;
  logic        seen_auto[$], seen_msb[$];
  asr_top u_dut (.clk(clk), .resetn(resetn), .serial_clk(sclk), .cs_n(cs_n),
    .serial_in_line(sdi), .lsb_order_select(sel), .cmp_in(cmp),
    .serial_out_line(sdo), .serial_out_oe_n(oe_n),
    .conversion_active_flag(busy), .sample_pos(), .sample_neg(),
    .mux_addr(addr), .res_valid(rvalid), .res_ready(res_ready),
    .res_data(rdata), .res_overrun(ovr));
  asr_host_model u_host (.serial_clk(sclk), .cs_n(cs_n), .serial_in_line(sdi),
    .lsb_order_select(sel), .cmp_in(cmp), .serial_out_line(sdo),
    .serial_out_oe_n(oe_n));
  asr_top #(.ORDER_MODE(asr_pkg::ORDER_AUTO)) u_auto (.clk(clk),
    .resetn(resetn), .serial_clk(sclk), .cs_n(cs_n), .serial_in_line(sdi),
    .lsb_order_select(sel), .cmp_in(cmp), .serial_out_line(sdo_auto),
    .serial_out_oe_n(), .conversion_active_flag(), .sample_pos(),
    .sample_neg(), .mux_addr(), .res_valid(), .res_ready(res_ready),
    .res_data(), .res_overrun());
  asr_top #(.ORDER_MODE(asr_pkg::ORDER_MSB_ONLY)) u_msb (.clk(clk),
    .resetn(resetn), .serial_clk(sclk), .cs_n(cs_n), .serial_in_line(sdi),
    .lsb_order_select(sel), .cmp_in(cmp), .serial_out_line(sdo_msb),
    .serial_out_oe_n(), .conversion_active_flag(), .sample_pos(),
    .sample_neg(), .mux_addr(), .res_valid(), .res_ready(res_ready),
    .res_data(), .res_overrun());
  // Same index as the host record: only bits taken while driven
  always @(posedge sclk) if (oe_n === 1'b0) begin
    seen_auto.push_back(sdo_auto);
    seen_msb.push_back(sdo_msb);
  end
  initial clk = 1'b0;
  always #10 clk = ~clk;
  always @(posedge clk) if (ovr === 1'b1) n_ovr++;
  function automatic logic exp_bit(input logic [7:0] r, input int j);
    if (j >= 1 && j <= 8) return r[8-j];
    if (j == 9 || j == 10) return r[0];
    if (j >= 11 && j <= 17) return r[j-10];
    return 1'b0;
  endfunction
  // Auto replay sends the LSB a second time, then seven more bits, then low
  function automatic logic exp_auto(input logic [7:0] r, input int j);
    if (j >= 1 && j <= 8) return r[8-j];
    if (j >= 9 && j <= 16) return r[j-9];
    return 1'b0;
  endfunction
  function automatic logic exp_msb(input logic [7:0] r, input int j);
    if (j >= 1 && j <= 8) return r[8-j];
    return 1'b0;
  endfunction
  task automatic run(input int n);
    logic [3:0] a;
    logic [7:0] r;
    a = 4'($random(seed));
    r = 8'($random(seed));
    seen_auto.delete();
    seen_msb.delete();
    u_host.frame(a, r, n);
    if (n > 9) exp_q.push_back({a, r});
    for (int j = 0; j < u_host.seen.size(); j++)
      `CHECK("out bit", exp_bit(r, j), u_host.seen[j])
    `CHECK("auto count", u_host.seen.size(), seen_auto.size())
    for (int j = 0; j < seen_auto.size(); j++) begin
      `CHECK("auto bit", exp_auto(r, j), seen_auto[j])
      `CHECK("msb bit", exp_msb(r, j), seen_msb[j])
    end
  endtask
  task automatic pop(input logic chk);
    int w;
    w = 0;
    @(posedge clk);
    #2;
    while (rvalid !== 1'b1 && w < 200) begin
      @(posedge clk);
      #2 w++;
    end
    `CHECK("res_valid", 1'b1, rvalid)
    if (chk) `CHECK("word", exp_q[0], rdata)
    void'(exp_q.pop_front());
    res_ready = 1'b1;
    @(posedge clk);
    #2 res_ready = 1'b0;
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Whole run needs about 6 us; about eight times that means a hang
  initial begin
    #50000 bad_count++;
    finish_test();
  end
  initial begin
    {resetn, res_ready} = 2'b00;
    repeat (2) @(posedge clk);
    #2 resetn = 1'b1;
    // Consumer stalls: eight queued, one pending, one dropped
    for (int f = 0; f < 10; f++)
      run(20);
    `CHECK("overruns", 1, n_ovr)
    // Eight from the FIFO, then the word that waited in the pending slot
    for (int f = 0; f < 9; f++)
      pop(1'b1);
    `CHECK("drained", 1'b0, rvalid)
    $display("fill and drain done");
    exp_q.delete();
    run(4);
    `CHECK("oe_n abort", 1'b1, oe_n)
    `CHECK("busy abort", 1'b0, busy)
    repeat (20) @(posedge clk);
    `CHECK("no word", 1'b0, rvalid)
    $display("abort done");
    run(20);
    pop(1'b1);
    $display("reselect done");
    finish_test();
  end
endmodule // test_adc_serial_result_output
